//--- core/fsp_pkg.sv
// Shared constants, types and helpers of the flash self-programming sequencer
package fsp_pkg;

  // ************************************************************
  // Address layout
  // ************************************************************
  // Program space in bytes; the pointer extension byte is used only above 64 Kbytes
  localparam int FLASH_BYTES = 65536;
  localparam bit EXT_PRESENT = (FLASH_BYTES > 65536);
  localparam int ADDR_W = 16;
  localparam int WORD_LSB = 1;
  localparam int WORD_W = 5;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_W = 10;
  localparam int BUF_DEPTH = 32;

  // ************************************************************
  // Control/status register layout
  // ************************************************************
  localparam int CSR_EN_BIT = 0;
  localparam int CSR_BUSY_BIT = 6;
  localparam int CSR_IE_BIT = 7;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_RWRE = 5'h11;
  localparam logic [4:0] CMD_RESET = 5'h00;

  // ************************************************************
  // Timing and reset values
  // ************************************************************
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [5:0] LOCK_RESET = 6'h3f;
  localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 10'h380;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE, ST_LOCK} fsp_state_t;

  // Command handed to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic [PAGE_W-1:0] page;
  } fsp_flash_cmd_t;

  // Page field of a byte pointer
  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] z);
    page_of = z[PAGE_LSB +: PAGE_W];
  endfunction : page_of

  // Page lies in the area that cannot be read during programming
  function automatic logic is_no_read_while_write_area(input logic [PAGE_W-1:0] pg);
    is_no_read_while_write_area = (pg >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE);
  endfunction : is_no_read_while_write_area

endpackage : fsp_pkg

//--- core/fsp_arm_window.sv
// Four-cycle window between a control write and the store instruction
`timescale 1ns/100ps
module fsp_arm_window (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Events
  input wire logic arm_in,
  input wire logic fire_in,
  // Window state
  output logic armed_out,
  output logic expired_out
);

  // Remaining cycles in the window
  logic [2:0] cnt_r;

  // ************************************************************
  // Window counter
  // ************************************************************
  // Loads on arm, drops on use, counts down otherwise
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_r <= 3'h0;
    end else if (arm_in) begin
      cnt_r <= fsp_pkg::ARM_CYCLES;
    end else if (fire_in) begin
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  // Window open while counter nonzero
  assign armed_out = (cnt_r != 3'h0);
  // Last cycle passed with no store instruction
  assign expired_out = (cnt_r == 3'h1) && !fire_in && !arm_in;

endmodule : fsp_arm_window

//--- core/fsp_page_buffer.sv
// Temporary page buffer with write-once slots
`timescale 1ns/100ps
module fsp_page_buffer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic clear_in,
  input wire logic load_in,
  input wire logic [fsp_pkg::WORD_W-1:0] load_idx_in,
  input wire logic [15:0] load_data_in,
  // Drain side
  input wire logic [fsp_pkg::WORD_W-1:0] rd_idx_in,
  output logic [15:0] rd_data_out
);

  // Word storage and written flags
  logic [15:0] mem_r [fsp_pkg::BUF_DEPTH];
  logic [fsp_pkg::BUF_DEPTH-1:0] used_r;

  // ************************************************************
  // Written flags
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || clear_in) begin
      used_r <= '0;
    end else if (load_in) begin
      used_r[load_idx_in] <= 1'b1;
    end
  end

  // ************************************************************
  // Storage
  // ************************************************************
  // Write once per slot
  always_ff @(posedge sys_clk_in) begin
    if (load_in && !clear_in && !used_r[load_idx_in]) begin
      mem_r[load_idx_in] <= load_data_in;
    end
  end

  // Erased slots read as all ones
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_data_out <= 16'hffff;
    end else begin
      rd_data_out <= used_r[rd_idx_in] ? mem_r[rd_idx_in] : 16'hffff;
    end
  end

  property p_write_once;
    @(posedge sys_clk_in) disable iff (rst_in)
    (load_in && !clear_in && used_r[load_idx_in]) |=>
      (mem_r[$past(load_idx_in)] == $past(mem_r[load_idx_in]));
  endproperty
  a_write_once: assert property (p_write_once) else $error("reloaded slot changed");

endmodule : fsp_page_buffer

//--- core/fsp_sequencer.sv
// Flash self-programming sequencer top
`timescale 1ns/100ps
module fsp_sequencer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Control register write and read
  input wire logic csr_we_in,
  input wire logic [7:0] csr_wdata_in,
  output logic [7:0] csr_rdata_out,
  // Pointer and data registers of the core
  input wire logic [7:0] z_pointer_low_in,
  input wire logic [7:0] z_pointer_high_in,
  input wire logic [7:0] z_pointer_extend_in,
  input wire logic [7:0] data_low_reg_in,
  input wire logic [7:0] data_high_reg_in,
  // Instruction strobes
  input wire logic store_prog_mem_in,
  input wire logic load_program_memory_instr_in,
  input wire logic eeprom_write_in,
  // Flash array side
  input wire logic flash_done_in,
  input wire logic chip_erase_in,
  input wire logic [fsp_pkg::WORD_W-1:0] flash_word_idx_in,
  output fsp_pkg::fsp_flash_cmd_t flash_cmd_out,
  output logic [15:0] flash_word_out,
  output logic [5:0] lock_bits_out,
  output logic [23:0] lpm_addr_out,
  // Core control
  output logic cpu_halt_out,
  output logic rw_area_block_out,
  output logic spm_irq_out
);

  // ************************************************************
  // Declarations
  // ************************************************************
  // Sequencer state
  fsp_pkg::fsp_state_t state_r;
  // Command bits of the control register
  logic [4:0] cmd_r;
  // Interrupt enable bit
  logic ie_r;
  // Read-while-write area busy flag
  logic rw_area_busy_r;
  // Lock bits, one means unprogrammed
  logic [5:0] lock_r;
  // Latched flash command
  fsp_pkg::fsp_flash_cmd_t flash_cmd_r;
  // Halt, block and interrupt flops
  logic halt_r;
  logic block_r;
  logic irq_r;
  // Read data and program-read address
  logic [7:0] csr_rdata_r;
  logic [23:0] lpm_addr_r;
  // Window state
  logic armed;
  logic expired;
  // Full pointer and its fields
  logic [23:0] z_full;
  logic [fsp_pkg::ADDR_W-1:0] z_addr;
  logic [fsp_pkg::PAGE_W-1:0] z_page;
  logic [fsp_pkg::WORD_W-1:0] z_word;
  // Accepted store instruction
  logic spm_go;
  logic do_load;
  logic do_erase;
  logic do_write;
  logic do_lock;
  logic do_rwre;
  logic buf_clear;

  // ************************************************************
  // Pointer decode
  // ************************************************************
  // Extension byte joins only for large space
  assign z_full = {fsp_pkg::EXT_PRESENT ? z_pointer_extend_in : 8'h00,
                   z_pointer_high_in, z_pointer_low_in};
  assign z_addr = z_full[fsp_pkg::ADDR_W-1:0];
  assign z_page = fsp_pkg::page_of(z_addr);
  assign z_word = z_addr[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];

  // ************************************************************
  // Command acceptance
  // ************************************************************
  // Only armed, idle stores act
  assign spm_go = store_prog_mem_in && armed && (state_r == fsp_pkg::ST_IDLE);
  assign do_load = spm_go && (cmd_r == fsp_pkg::CMD_LOAD);
  assign do_erase = spm_go && (cmd_r == fsp_pkg::CMD_ERASE);
  assign do_write = spm_go && (cmd_r == fsp_pkg::CMD_WRITE);
  assign do_lock = spm_go && (cmd_r == fsp_pkg::CMD_LOCK);
  // Read-enable pattern
  assign do_rwre = spm_go && (cmd_r == fsp_pkg::CMD_RWRE);
  // Clear after page write, read enable and EEPROM write
  assign buf_clear = do_rwre || eeprom_write_in ||
                     ((state_r == fsp_pkg::ST_WRITE) && flash_done_in);

  // Four-cycle arming window
  fsp_arm_window u_arm (
    .sys_clk_in (sys_clk_in),
    .rst_in (rst_in),
    .arm_in (csr_we_in && csr_wdata_in[fsp_pkg::CSR_EN_BIT]),
    .fire_in (store_prog_mem_in),
    .armed_out (armed),
    .expired_out (expired)
  );

  fsp_page_buffer u_buf (
    .sys_clk_in (sys_clk_in),
    .rst_in (rst_in),
    .clear_in (buf_clear),
    .load_in (do_load),
    .load_idx_in (z_word),
    .load_data_in ({data_high_reg_in, data_low_reg_in}),
    .rd_idx_in (flash_word_idx_in),
    .rd_data_out (flash_word_out)
  );

  // ************************************************************
  // Sequencer state
  // ************************************************************
  // Runs one flash operation until the array reports done
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= fsp_pkg::ST_IDLE;
    end else begin
      case (state_r)
        // Wait for an accepted command
        fsp_pkg::ST_IDLE: begin
          if (do_erase) begin
            state_r <= fsp_pkg::ST_ERASE;
          end else if (do_write) begin
            state_r <= fsp_pkg::ST_WRITE;
          end else if (do_lock) begin
            state_r <= fsp_pkg::ST_LOCK;
          end
        end
        // Operations end on array done
        fsp_pkg::ST_ERASE, fsp_pkg::ST_WRITE, fsp_pkg::ST_LOCK: begin
          if (flash_done_in) begin
            state_r <= fsp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= fsp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Control register bits
  // ************************************************************
  // Command bits held through an operation, cleared at its end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmd_r <= fsp_pkg::CMD_RESET;
    end else if (csr_we_in && (state_r == fsp_pkg::ST_IDLE)) begin
      cmd_r <= csr_wdata_in[4:0];
    end else if (((state_r != fsp_pkg::ST_IDLE) && flash_done_in) || do_load || do_rwre) begin
      cmd_r <= fsp_pkg::CMD_RESET;
    end else if (expired && (state_r == fsp_pkg::ST_IDLE)) begin
      cmd_r <= fsp_pkg::CMD_RESET;
    end
  end

  // Interrupt enable follows every write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ie_r <= 1'b0;
    end else if (csr_we_in) begin
      ie_r <= csr_wdata_in[fsp_pkg::CSR_IE_BIT];
    end
  end

  // Busy set by erase or write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rw_area_busy_r <= 1'b0;
    end else if (do_erase || do_write) begin
      rw_area_busy_r <= 1'b1;
    end else if (do_rwre) begin
      rw_area_busy_r <= 1'b0;
    end
  end

  // ************************************************************
  // Flash command and lock bits
  // ************************************************************
  // Page latched once per erase or write operation
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flash_cmd_r <= '0;
    end else begin
      // One-cycle command pulses
      flash_cmd_r.erase <= do_erase;
      flash_cmd_r.write <= do_write;
      flash_cmd_r.lock <= do_lock;
      if (do_erase || do_write) begin
        flash_cmd_r.page <= z_page;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lock_r <= fsp_pkg::LOCK_RESET;
    end else if (chip_erase_in) begin
      lock_r <= fsp_pkg::LOCK_RESET;
    end else if (do_lock) begin
      lock_r <= lock_r & data_low_reg_in[5:0];
    end
  end

  // ************************************************************
  // Core control outputs
  // ************************************************************
  // Halt only for no-read area target
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      halt_r <= 1'b0;
    end else if (do_erase || do_write) begin
      halt_r <= fsp_pkg::is_no_read_while_write_area(z_page);
    end else if (flash_done_in) begin
      halt_r <= 1'b0;
    end
  end

  // Area blocked through erase or write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      block_r <= 1'b0;
    end else if (do_erase || do_write) begin
      block_r <= 1'b1;
    end else if (flash_done_in) begin
      block_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ie_r && !cmd_r[fsp_pkg::CSR_EN_BIT];
    end
  end

  // Register read image
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      csr_rdata_r <= 8'h00;
    end else begin
      csr_rdata_r <= {ie_r, rw_area_busy_r, 1'b0, cmd_r};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lpm_addr_r <= 24'h000000;
    end else if (load_program_memory_instr_in) begin
      lpm_addr_r <= z_full;
    end
  end

  assign csr_rdata_out = csr_rdata_r;
  assign flash_cmd_out = flash_cmd_r;
  assign lock_bits_out = lock_r;
  assign lpm_addr_out = lpm_addr_r;
  assign cpu_halt_out = halt_r;
  assign rw_area_block_out = block_r;
  assign spm_irq_out = irq_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_armed_idle;
    csr_we_in && csr_wdata_in[0] && (state_r == fsp_pkg::ST_IDLE);
  endsequence
  sequence s_quiet4;
    (!store_prog_mem_in && !csr_we_in && !flash_done_in)[*4];
  endsequence

  property p_auto_clear;
    s_armed_idle ##1 s_quiet4 |=> !cmd_r[0];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("enable not cleared");
  property p_page_latched;
    (state_r != fsp_pkg::ST_IDLE) && !flash_done_in |=> $stable(flash_cmd_r.page);
  endproperty
  a_page_latched: assert property (p_page_latched) else $error("page moved");
  property p_halt_no_read_while_write_area;
    (do_erase || do_write) |=> (halt_r == fsp_pkg::is_no_read_while_write_area($past(z_page)));
  endproperty
  a_halt_no_read_while_write_area: assert property (p_halt_no_read_while_write_area) else $error("halt wrong");
  property p_busy_during;
    (state_r == fsp_pkg::ST_ERASE) || (state_r == fsp_pkg::ST_WRITE) |->
      rw_area_busy_r && block_r;
  endproperty
  a_busy_during: assert property (p_busy_during) else $error("area not busy");
  property p_lock_free;
    (state_r == fsp_pkg::ST_LOCK) && !$past(do_erase || do_write) |-> !halt_r && !block_r;
  endproperty
  a_lock_free: assert property (p_lock_free) else $error("lock op blocked");
  property p_irq_level;
    ie_r && !cmd_r[0] |=> spm_irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing");
  property p_lock_update;
    do_lock && !chip_erase_in |=> lock_r == ($past(lock_r) & $past(data_low_reg_in[5:0]));
  endproperty
  a_lock_update: assert property (p_lock_update) else $error("lock bits wrong");
  property p_busy_clear;
    $fell(rw_area_busy_r) |-> $past(do_rwre);
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy cleared early");
  property p_unarmed;
    store_prog_mem_in && !armed && (state_r == fsp_pkg::ST_IDLE) |=>
      (state_r == fsp_pkg::ST_IDLE) && !flash_cmd_r.erase && !flash_cmd_r.write;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed store acted");

endmodule : fsp_sequencer

//--- tb/fsp_cpu_model.sv
// CPU core model that issues loader instructions to the sequencer
`timescale 1ns/100ps
module fsp_cpu_model (
  // Clock
  input wire logic sys_clk_in,
  // Control register write
  output logic csr_we_out,
  output logic [7:0] csr_wdata_out,
  // Pointer bytes and data pair
  output logic [23:0] z_out,
  output logic [15:0] data_out,
  // Instruction strobes
  output logic store_out,
  output logic load_out
);
  // Quiet core at time zero
  initial begin
    csr_we_out = 1'b0;
    csr_wdata_out = 8'h00;
    z_out = 24'h000000;
    data_out = 16'h0000;
    store_out = 1'b0;
    load_out = 1'b0;
  end

  // One control register write, strobe held for one edge
  task automatic csr(input logic [7:0] val);
    @(posedge sys_clk_in);
    #1;
    csr_we_out = 1'b1;
    csr_wdata_out = val;
    @(posedge sys_clk_in);
    #1;
    csr_we_out = 1'b0;
  endtask : csr

  // Pointer move, as the loader reuses the pointer freely
  task automatic set_z(input logic [15:0] z);
    z_out = {8'h00, z};
  endtask : set_z

  // Control write then store instruction gap cycles later
  // store in window for gap up to 4
  task automatic spm(input logic [7:0] cmd, input logic [15:0] z, input logic [15:0] d,
      input int gap);
    z_out = {8'h00, z};
    data_out = d;
    csr(cmd);
    if (gap > 1) begin
      repeat (gap - 1) @(posedge sys_clk_in);
      #1;
    end
    store_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    store_out = 1'b0;
  endtask : spm

  // Lock setting with pointer one and upper data bits high
  // recommended lock form
  task automatic lock(input logic [5:0] bits);
    spm(8'h09, 16'h0001, {10'h003, bits}, 1);
  endtask : lock

  // Program read instruction, extension byte included
  task automatic load_program_memory_instr(input logic [23:0] z);
    z_out = z;
    load_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    load_out = 1'b0;
  endtask : load_program_memory_instr
endmodule : fsp_cpu_model

//--- tb/tb_top.sv
// Self-checking bench of the flash self-programming sequencer
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL %s exp %h got %h", nm, exp, got); end end
module tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  logic sys_clk_in;
  logic rst_in;
  logic csr_we, store, load_program_memory_instr, eew, done_p, cerase, halt, block, irq;
  logic [7:0] csr_wdata, csr_rd;
  logic [23:0] z, lpm_addr;
  logic [15:0] dat, fword;
  logic [4:0] idx;
  logic [5:0] lockb;
  fsp_pkg::fsp_flash_cmd_t fcmd, seen;
  int errors = 0;
  int total_checks = 0;
  // Strobe selectors of the pulse task
  localparam int P_EEW = 0;
  localparam int P_DONE = 1;
  localparam int P_CERASE = 2;

  // 40 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // ************************************************************
  // Instances
  // ************************************************************
  fsp_cpu_model i_cpu (.sys_clk_in(sys_clk_in), .csr_we_out(csr_we), .csr_wdata_out(csr_wdata),
    .z_out(z), .data_out(dat), .store_out(store), .load_out(load_program_memory_instr));
  fsp_sequencer i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .csr_we_in(csr_we),
    .csr_wdata_in(csr_wdata), .csr_rdata_out(csr_rd), .z_pointer_low_in(z[7:0]),
    .z_pointer_high_in(z[15:8]), .z_pointer_extend_in(z[23:16]), .data_low_reg_in(dat[7:0]),
    .data_high_reg_in(dat[15:8]), .store_prog_mem_in(store),
    .load_program_memory_instr_in(load_program_memory_instr), .eeprom_write_in(eew), .flash_done_in(done_p),
    .chip_erase_in(cerase), .flash_word_idx_in(idx), .flash_cmd_out(fcmd),
    .flash_word_out(fword), .lock_bits_out(lockb), .lpm_addr_out(lpm_addr),
    .cpu_halt_out(halt), .rw_area_block_out(block), .spm_irq_out(irq));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // One-cycle pulse on one bench strobe, then settle
  task automatic pulse(input int which);
    @(posedge sys_clk_in);
    #1;
    eew = (which == P_EEW);
    done_p = (which == P_DONE);
    cerase = (which == P_CERASE);
    @(posedge sys_clk_in);
    #1;
    eew = 1'b0;
    done_p = 1'b0;
    cerase = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask : pulse

  // Buffer slot as the array reads it
  task automatic word_is(input logic [4:0] i, input logic [15:0] exp);
    idx = i;
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("buffer word", exp, fword)
  endtask : word_is

  // Start an operation and catch its command pulse
  task automatic run_op(input logic [7:0] cmd, input logic [15:0] zv);
    seen = '0;
    i_cpu.spm(cmd, zv, 16'h5a5a, 1);
    repeat (4) begin
      if (fcmd.erase | fcmd.write | fcmd.lock) seen = fcmd;
      @(posedge sys_clk_in);
      #1;
    end
  endtask : run_op

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    errors++;
    tally_and_finish();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    rst_in = 1'b1;
    eew = 1'b0;
    done_p = 1'b0;
    cerase = 1'b0;
    idx = 5'h00;
    repeat (20) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    // Reset image
    `CHK("csr", 8'h00, csr_rd)
    `CHK("lock", 6'h3f, lockb)
    `CHK("halt", 1'b0, halt)
    `CHK("block", 1'b0, block)
    `CHK("irq", 1'b0, irq)
    word_is(5'h00, 16'hffff);
    // Out-of-order loads, window edge, repeat and late store
    i_cpu.spm(8'h01, 16'h0006, 16'h1234, 1);
    i_cpu.spm(8'h01, 16'h0000, 16'habcd, 4);
    i_cpu.spm(8'h01, 16'h0006, 16'h5555, 1);
    i_cpu.spm(8'h01, 16'h0008, 16'h7777, 6);
    `CHK("csr after lapse", 8'h00, csr_rd)
    word_is(5'h03, 16'h1234);
    word_is(5'h00, 16'habcd);
    word_is(5'h04, 16'hffff);
    i_cpu.spm(8'h01, 16'h0006, 16'h5555, 1);
    word_is(5'h03, 16'h1234);
    // EEPROM write drops loaded words
    pulse(P_EEW);
    word_is(5'h03, 16'hffff);
    // Erase, fill, then write one page
    run_op(8'h03, 16'h0140);
    `CHK("erase pulse", 1'b1, seen.erase)
    `CHK("erase page", 10'h005, seen.page)
    `CHK("halt", 1'b0, halt)
    `CHK("block", 1'b1, block)
    `CHK("busy", 1'b1, csr_rd[6])
    // Pointer moved mid-operation must not move the page
    i_cpu.set_z(16'hffc0);
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("latched page", 10'h005, fcmd.page)
    pulse(P_DONE);
    `CHK("block", 1'b0, block)
    `CHK("busy", 1'b1, csr_rd[6])
    i_cpu.spm(8'h11, 16'h0000, 16'h0000, 1);
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("busy", 1'b0, csr_rd[6])
    // Fill then write the same page
    i_cpu.spm(8'h01, 16'h0144, 16'h2222, 1);
    word_is(5'h02, 16'h2222);
    run_op(8'h05, 16'h0140);
    `CHK("write pulse", 1'b1, seen.write)
    `CHK("write page", 10'h005, seen.page)
    pulse(P_DONE);
    word_is(5'h02, 16'hffff);
    i_cpu.spm(8'h11, 16'h0000, 16'h0000, 1);
    // Read-enable store empties the buffer
    i_cpu.spm(8'h01, 16'h0002, 16'h3333, 1);
    i_cpu.spm(8'h11, 16'h0000, 16'h0000, 1);
    word_is(5'h01, 16'hffff);
    // Erase in the halting area
    run_op(8'h03, 16'he000);
    `CHK("no_read_while_write_area page", 10'h380, seen.page)
    `CHK("halt", 1'b1, halt)
    pulse(P_DONE);
    `CHK("halt", 1'b0, halt)
    i_cpu.spm(8'h11, 16'h0000, 16'h0000, 1);
    // Lock setting, software cannot unprogram
    seen = '0;
    i_cpu.lock(6'h2d);
    repeat (4) begin
      if (fcmd.lock) seen = fcmd;
      `CHK("halt", 1'b0, halt)
      `CHK("block", 1'b0, block)
      @(posedge sys_clk_in);
      #1;
    end
    `CHK("lock pulse", 1'b1, seen.lock)
    `CHK("lock page", 10'h380, seen.page)
    pulse(P_DONE);
    `CHK("lock", 6'h2d, lockb)
    i_cpu.lock(6'h3e);
    repeat (3) @(posedge sys_clk_in);
    pulse(P_DONE);
    `CHK("lock", 6'h2c, lockb)
    pulse(P_CERASE);
    `CHK("lock", 6'h3f, lockb)
    // Byte-addressed program read; no extension byte at this size
    i_cpu.load_program_memory_instr(24'h5a1235);
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK("lpm addr", 24'h001235, lpm_addr)
    // Interrupt while enable bit clear
    i_cpu.csr(8'h80);
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("irq", 1'b1, irq)
    i_cpu.csr(8'h00);
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("irq", 1'b0, irq)
    tally_and_finish();
  end
endmodule : tb_top
